//--- logic/dps_sem_host.sv
// Semaphore port controller: claims, releases, reads and initialises flags
`timescale 1ns/1ps
`default_nettype none
module dps_sem_host import dps_pkg::*; #(
  parameter int unsigned MAX_POLLS = 4
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              req_valid,
  input  wire dps_req_t          req,
  output var  logic              req_ready,
  output var  dps_resp_t         resp,
  output var  dps_pins_t         pins,
  input  wire logic [DATA_W-1:0] data_in
);

  if (MAX_POLLS > (1 << POLL_W) - 1 || GAP_C < 2 || ACCESS_C >= (1 << CNT_W)) begin : g_chk
    $error("dps_sem_host: parameter out of range");
  end

  typedef struct packed {
    dps_state_t        st;
    dps_op_t           op;
    logic [IDX_W-1:0]  idx;
    logic              wval;
    logic              init;
    logic [POLL_W-1:0] poll;
    logic [CNT_W-1:0]  cnt;
    logic              ready;
    dps_resp_t         resp;
    dps_pins_t         pins;
  } dps_host_t;

  logic      rst_meta_q;
  logic      rst_q;
  dps_host_t s_q;
  dps_host_t s_d;

  // Reset released through two flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_q      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_q      <= rst_meta_q;
    end
  end

  always_comb begin
    s_d           = s_q;
    s_d.resp.done = 1'b0;
    if (s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
    case (s_q.st)
      DPS_S_IDLE: begin
        s_d.pins = PINS_IDLE;
        if (s_q.init) begin
          s_d.op    = DPS_OP_INIT;
          s_d.wval  = 1'b1;
          s_d.ready = 1'b0;
          s_d.st    = DPS_S_WR_SET;
          s_d.cnt   = CNT_W'(SETUP_C);
        end else if (req_valid && s_q.ready) begin
          s_d.op    = req.op;
          s_d.idx   = req.idx;
          s_d.poll  = '0;
          s_d.ready = 1'b0;
          s_d.wval  = (req.op != DPS_OP_CLAIM);
          s_d.st    = (req.op == DPS_OP_READ) ? DPS_S_RD_ACT : DPS_S_WR_SET;
          s_d.cnt   = CNT_W'((req.op == DPS_OP_READ) ? ACCESS_C : SETUP_C);
        end
      end
      DPS_S_WR_SET: begin
        s_d.pins.flag_space_select_n = 1'b0;
        s_d.pins.ce_n                = 1'b1;
        s_d.pins.flag_index_lines    = s_q.idx;
        s_d.pins.dout                = {DATA_W{s_q.wval}};
        s_d.pins.dout_oe_n           = 1'b0;
        if (s_q.cnt == '0) begin
          s_d.pins.rw_n = 1'b0;
          s_d.st        = DPS_S_WR_PULSE;
          s_d.cnt       = CNT_W'(WPULSE_C);
        end
      end
      DPS_S_WR_PULSE: begin
        if (s_q.cnt == '0) begin
          s_d.pins = PINS_IDLE;
          s_d.st   = DPS_S_WR_END;
          s_d.cnt  = CNT_W'(GAP_C);
        end
      end
      DPS_S_WR_END: begin
        if (s_q.cnt == '0) begin
          case (s_q.op)
            DPS_OP_INIT: begin
              s_d.idx = s_q.idx + 1'b1;
              s_d.st  = DPS_S_IDLE;
              if (s_q.idx == LAST_IDX) begin
                s_d.init  = 1'b0;
                s_d.ready = 1'b1;
              end
            end
            DPS_OP_CLAIM: begin
              s_d.st  = DPS_S_RD_ACT;
              s_d.cnt = CNT_W'(ACCESS_C);
            end
            default: begin
              s_d.resp.done = 1'b1;
              s_d.resp.won  = 1'b0;
              s_d.ready     = 1'b1;
              s_d.st        = DPS_S_IDLE;
            end
          endcase
        end
      end
      DPS_S_RD_ACT: begin
        s_d.pins.flag_space_select_n = 1'b0;
        s_d.pins.ce_n                = 1'b1;
        s_d.pins.oe_n                = 1'b0;
        s_d.pins.flag_index_lines    = s_q.idx;
        if (s_q.cnt == '0) begin
          s_d.resp.rdata = data_in;
          s_d.resp.won   = ~data_in[FLAG_BIT];
          s_d.pins       = PINS_IDLE;
          s_d.st         = DPS_S_RD_END;
          s_d.cnt        = CNT_W'(GAP_C);
        end
      end
      DPS_S_RD_END: begin
        if (s_q.cnt == '0) begin
          if (s_q.op == DPS_OP_CLAIM && !s_q.resp.won && s_q.poll < POLL_W'(MAX_POLLS)) begin
            s_d.poll = s_q.poll + 1'b1;
            s_d.st   = DPS_S_RD_ACT;
            s_d.cnt  = CNT_W'(ACCESS_C);
          end else if (s_q.op == DPS_OP_CLAIM && !s_q.resp.won) begin
            s_d.op   = DPS_OP_WITHDRAW;
            s_d.wval = 1'b1;
            s_d.st   = DPS_S_WR_SET;
            s_d.cnt  = CNT_W'(SETUP_C);
          end else begin
            s_d.resp.done = 1'b1;
            s_d.ready     = 1'b1;
            s_d.st        = DPS_S_IDLE;
          end
        end
      end
      default: begin
        s_d.st = DPS_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_q) begin
    if (!rst_q) begin
      s_q       <= '0;
      s_q.st    <= DPS_S_IDLE;
      s_q.init  <= 1'b1;
      s_q.pins  <= PINS_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign req_ready = s_q.ready;
  assign resp      = s_q.resp;
  assign pins      = s_q.pins;

  // Checking helpers
  logic       rd_act;
  logic       wr_act;
  logic       claim_wrote_q;
  logic [3:0] init_wr_q;
  assign rd_act = !s_q.pins.flag_space_select_n && !s_q.pins.oe_n;
  assign wr_act = !s_q.pins.flag_space_select_n && !s_q.pins.rw_n;

  always_ff @(posedge mclk or negedge rst_q) begin
    if (!rst_q) begin
      claim_wrote_q <= 1'b0;
      init_wr_q     <= 4'h0;
    end else begin
      if (s_q.st == DPS_S_IDLE) begin
        claim_wrote_q <= 1'b0;
      end else if (wr_act && s_q.op == DPS_OP_CLAIM && !s_q.pins.dout[FLAG_BIT]) begin
        claim_wrote_q <= 1'b1;
      end
      if (s_q.init && wr_act && !$past(wr_act) && s_q.pins.dout[FLAG_BIT]) begin
        init_wr_q <= init_wr_q + 4'h1;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_q);

  sequence s_lost_final;
    s_q.st == DPS_S_RD_END && s_q.cnt == '0 && s_q.op == DPS_OP_CLAIM
      && !s_q.resp.won && s_q.poll >= POLL_W'(MAX_POLLS);
  endsequence

  sequence s_write_one;
    wr_act && s_q.pins.dout[FLAG_BIT] && !s_q.pins.dout_oe_n;
  endsequence

  a_ce_held_high: assert property (!s_q.pins.flag_space_select_n |-> s_q.pins.ce_n)
    else $error("RAM enable low during flag access");
  a_strobe_selected: assert property ((wr_act || !s_q.pins.oe_n) |-> !s_q.pins.flag_space_select_n
    && !(wr_act && !s_q.pins.oe_n))
    else $error("strobe without flag select or both strobes");
  a_poll_gap: assert property (rd_act ##1 !rd_act |-> !rd_act[*2])
    else $error("reads not separated by deselect");
  a_write_first: assert property ($rose(rd_act) && s_q.op == DPS_OP_CLAIM |-> claim_wrote_q)
    else $error("claim read before zero write");
  a_withdraw_lost: assert property (s_lost_final |-> ##[1:40] s_write_one)
    else $error("lost claim not withdrawn");
  a_init_eight: assert property ($fell(s_q.init) |-> init_wr_q == 4'h8 && s_q.ready)
    else $error("init did not free all eight flags");
  a_no_ready_init: assert property (s_q.init |-> !s_q.ready)
    else $error("request accepted during init");

endmodule
`default_nettype wire

//--- logic/dps_pkg.sv
// Package: constants and carrier types for the semaphore port controller
//
// Contract
// - Flag space chosen by low select, other controls as static RAM.
// - Polling reads must deassert select or output enable between reads.
// - Claim by writing zero first, then read back; never read first.
// - Failed claim is followed by more reads or a withdrawing one.
// - After power-up write one to all eight flags from each port.
// - Hold the RAM chip enable high while the flag select is low.
package dps_pkg;

  localparam int unsigned DATA_W      = 18;
  localparam int unsigned IDX_W       = 3;
  localparam int unsigned FLAG_COUNT  = 8;
  localparam int unsigned CNT_W       = 8;
  localparam int unsigned POLL_W      = 8;
  localparam int unsigned FLAG_BIT    = 0;

  // Clock period and pin timing, in their own units
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned T_SETUP_NS    = 5;
  localparam int unsigned T_WPULSE_NS   = 15;
  localparam int unsigned T_ACCESS_NS   = 20;
  localparam int unsigned T_GAP_NS      = 10;

  // Least times round up to whole cycles
  localparam int unsigned SETUP_C  = (T_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WPULSE_C = (T_WPULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned ACCESS_C = (T_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned GAP_C    = (T_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  localparam logic [IDX_W-1:0] LAST_IDX = 3'h7;

  typedef enum logic [2:0] {
    DPS_OP_READ,
    DPS_OP_CLAIM,
    DPS_OP_RELEASE,
    DPS_OP_INIT,
    DPS_OP_WITHDRAW
  } dps_op_t;

  typedef enum logic [2:0] {
    DPS_S_IDLE,
    DPS_S_WR_SET,
    DPS_S_WR_PULSE,
    DPS_S_WR_END,
    DPS_S_RD_ACT,
    DPS_S_RD_END
  } dps_state_t;

  // Pins toward one port of the dual-port part
  typedef struct packed {
    logic              flag_space_select_n;
    logic              ce_n;
    logic              rw_n;
    logic              oe_n;
    logic [IDX_W-1:0]  flag_index_lines;
    logic [DATA_W-1:0] dout;
    logic              dout_oe_n;
  } dps_pins_t;

  typedef struct packed {
    dps_op_t          op;
    logic [IDX_W-1:0] idx;
  } dps_req_t;

  typedef struct packed {
    logic              done;
    logic              won;
    logic [DATA_W-1:0] rdata;
  } dps_resp_t;

  localparam dps_pins_t PINS_IDLE = '{
    flag_space_select_n: 1'b1, ce_n: 1'b1, rw_n: 1'b1, oe_n: 1'b1,
    flag_index_lines: 3'h0, dout: 18'h3FFFF, dout_oe_n: 1'b1
  };

endpackage

//--- dv/dps_sem_model.sv
// Behavioural two-port flag part: one port faces the host, one the bench
`timescale 1ns/1ps
`default_nettype none
module dps_sem_model import dps_pkg::*; (
  input  wire dps_pins_t         pins_a,
  output var  logic [DATA_W-1:0] bus_a,
  input  wire logic              sel_b_n,
  input  wire logic              rw_b_n,
  input  wire logic              oe_b_n,
  input  wire logic [IDX_W-1:0]  idx_b,
  input  wire logic [DATA_W-1:0] d_b,
  output var  logic [DATA_W-1:0] bus_b
);
  logic [FLAG_COUNT-1:0] req_a_n = '0;
  logic [FLAG_COUNT-1:0] req_b_n = '1;
  logic [FLAG_COUNT-1:0] own_a   = '1;
  logic [FLAG_COUNT-1:0] own_b   = '0;
  logic [DATA_W-1:0]     cap_a   = '0;
  logic [DATA_W-1:0]     cap_b   = '0;
  logic                  act_a;
  logic                  act_b;
  // Power-up leaves stale host-side claims, so the host must clear them

  task automatic resolve(input int i);
    if (own_a[i] && req_a_n[i]) own_a[i] = 1'b0;
    if (own_b[i] && req_b_n[i]) own_b[i] = 1'b0;
    if (!own_a[i] && !own_b[i]) begin
      if (!req_a_n[i]) own_a[i] = 1'b1;
      else if (!req_b_n[i]) own_b[i] = 1'b1;
    end
  endtask

  always @(negedge pins_a.rw_n) begin
    if (!pins_a.flag_space_select_n && pins_a.ce_n) begin
      req_a_n[pins_a.flag_index_lines] = pins_a.dout[FLAG_BIT];
      resolve(int'(pins_a.flag_index_lines));
    end
  end
  always @(negedge rw_b_n) begin
    if (!sel_b_n) begin
      req_b_n[idx_b] = d_b[FLAG_BIT];
      resolve(int'(idx_b));
    end
  end

  assign act_a = !pins_a.flag_space_select_n && !pins_a.oe_n && pins_a.ce_n;
  assign act_b = !sel_b_n && !oe_b_n;
  // value spread and latched at read start
  always @(posedge act_a) cap_a = {DATA_W{~own_a[pins_a.flag_index_lines]}};
  always @(posedge act_b) cap_b = {DATA_W{~own_b[idx_b]}};
  // Released bus shows the inverse so stale data never passes
  assign bus_a = !pins_a.dout_oe_n ? pins_a.dout : (act_a ? cap_a : ~cap_a);
  assign bus_b = act_b ? cap_b : ~cap_b;
endmodule
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench for the flag port controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin err_total++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module testbench import dps_pkg::*; ;
  logic              mclk = 1'b0;
  logic              rst_n = 1'b0;
  logic              req_valid = 1'b0;
  dps_req_t          req = '{op: DPS_OP_READ, idx: 3'h0};
  logic              req_ready;
  dps_resp_t         resp;
  dps_pins_t         pins;
  logic [DATA_W-1:0] bus_a;
  logic              sel_b_n = 1'b1;
  logic              rw_b_n = 1'b1;
  logic              oe_b_n = 1'b1;
  logic [IDX_W-1:0]  idx_b = 3'h0;
  logic [DATA_W-1:0] d_b = 18'h3FFFF;
  logic [DATA_W-1:0] bus_b;
  int                err_total = 0;
  int                cmp_count = 0;
  int                cyc = 0;

  always #2 mclk = ~mclk;

  dps_sem_host #(.MAX_POLLS(1)) i_dut (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .resp(resp), .pins(pins), .data_in(bus_a));
  dps_sem_model i_far (.pins_a(pins), .bus_a(bus_a), .sel_b_n(sel_b_n), .rw_b_n(rw_b_n),
    .oe_b_n(oe_b_n), .idx_b(idx_b), .d_b(d_b), .bus_b(bus_b));

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end

  task automatic host(input dps_op_t op, input logic [IDX_W-1:0] i, input logic won);
    int n;
    n = 0;
    do begin @(posedge mclk); #1; n++; end while (req_ready !== 1'b1 && n < 500);
    req_valid = 1'b1;
    req.op = op;
    req.idx = i;
    @(posedge mclk); #1;
    req_valid = 1'b0;
    `CHK("ready", 1'b0, req_ready)
    n = 0;
    while (resp.done !== 1'b1 && n < 500) begin @(posedge mclk); #1; n++; end
    `CHK("done", 1'b1, resp.done)
    `CHK("won", won, resp.won)
    if (op != DPS_OP_RELEASE) `CHK("rdata", {DATA_W{~won}}, resp.rdata)
  endtask

  task automatic b_wr(input logic [IDX_W-1:0] i, input logic v);
    @(posedge mclk); #1 sel_b_n = 1'b0; idx_b = i; d_b = {DATA_W{v}};
    @(posedge mclk); #1 rw_b_n = 1'b0;
    repeat (4) @(posedge mclk);
    #1 rw_b_n = 1'b1;
    @(posedge mclk); #1 sel_b_n = 1'b1; d_b = ~d_b;
  endtask

  // Select drops between reads so every read recaptures
  task automatic b_rd(input logic [IDX_W-1:0] i, input logic ex);
    @(posedge mclk); #1 sel_b_n = 1'b0; idx_b = i; oe_b_n = 1'b0;
    repeat (5) @(posedge mclk);
    `CHK("flag_b", {DATA_W{ex}}, bus_b)
    #1 sel_b_n = 1'b1; oe_b_n = 1'b1;
  endtask

  task automatic t_init();
    for (int i = 0; i < FLAG_COUNT; i++) begin
      b_wr(3'(i), 1'b1);
      b_rd(3'(i), 1'b1);
      host(DPS_OP_READ, 3'(i), 1'b0);
    end
    $display("test init done");
  endtask

  task automatic t_claim();
    for (int i = 0; i < FLAG_COUNT; i++) begin
      host(DPS_OP_CLAIM, 3'(i), 1'b1);
      b_rd(3'(i), 1'b1);
      host(DPS_OP_RELEASE, 3'(i), 1'b0);
      b_wr(3'(i), 1'b0);
      b_rd(3'(i), 1'b0);
      b_wr(3'(i), 1'b1);
    end
    $display("test claim done");
  endtask

  task automatic t_lost();
    b_wr(3'h3, 1'b0);
    host(DPS_OP_CLAIM, 3'h3, 1'b0);
    b_wr(3'h3, 1'b1);
    host(DPS_OP_READ, 3'h3, 1'b0);
    $display("test lost done");
  endtask

  task automatic t_pass();
    host(DPS_OP_CLAIM, 3'h5, 1'b1);
    b_wr(3'h5, 1'b0);
    b_rd(3'h5, 1'b1);
    host(DPS_OP_RELEASE, 3'h5, 1'b0);
    b_rd(3'h5, 1'b0);
    host(DPS_OP_READ, 3'h5, 1'b0);
    b_wr(3'h5, 1'b1);
    host(DPS_OP_READ, 3'h5, 1'b0);
    $display("test pass done");
  endtask

  // Far read held open while ownership passes to it
  task automatic t_hold();
    host(DPS_OP_CLAIM, 3'h6, 1'b1);
    b_wr(3'h6, 1'b0);
    @(posedge mclk); #1 sel_b_n = 1'b0; idx_b = 3'h6; oe_b_n = 1'b0;
    host(DPS_OP_RELEASE, 3'h6, 1'b0);
    `CHK("held_b", {DATA_W{1'b1}}, bus_b)
    sel_b_n = 1'b1;
    oe_b_n = 1'b1;
    b_rd(3'h6, 1'b0);
    b_wr(3'h6, 1'b1);
    $display("test hold done");
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    #1 rst_n = 1'b1;
    t_init();
    t_claim();
    t_lost();
    t_pass();
    t_hold();
    summarize();
  end
endmodule
`default_nettype wire
